// ---- acc_cmp_model.sv ----
// Purpose: behavioural analog comparator core
// Assumes: levels in millivolts from the bench
// Notes:   chatters while powered down, as a real core may
module acc_cmp_model (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // config and analog levels
    input  wire acc_pkg::acc_analog_t cfg,
    input  wire logic [11:0]          pos_mv,
    input  wire logic [11:0]          ch3_mv,
    input  wire logic [11:0]          conv_mv,
    output logic                      cmp_result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] neg;
    logic [11:0] hys;
    logic [1:0]  cnt_q;
    logic [1:0]  cnt_d;
    logic        res_d;
    always_comb begin
        case (cfg.negative_input_select)
            2'h1:    neg = ch3_mv;
            2'h2:    neg = conv_mv;
            default: neg = pos_mv;
        endcase
        hys = cfg.hysteresis_on ? 12'h004 : 12'h000;
        // slow codes update less often
        cnt_d = (cnt_q == 2'h3 - cfg.response_time_select) ? 2'h0 : cnt_q + 2'h1;
        res_d = cmp_result;
        if (!cfg.comparator_on)
            res_d = ~cmp_result;
        else if (cnt_d == 2'h0 && pos_mv > neg + hys)
            res_d = 1'b1;
        else if (cnt_d == 2'h0 && pos_mv + hys < neg)
            res_d = 1'b0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q      <= 2'h0;
            cmp_result <= 1'b0;
        end else begin
            cnt_q      <= cnt_d;
            cmp_result <= res_d;
        end
    end
endmodule // acc_cmp_model

// ---- acc_edge.sv ----
// Purpose: edge finder on the comparator output
// Assumes: level is already a flop output
// Notes:   history held low while disabled
module acc_edge (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // level in, edges out
    input  wire logic          enable,
    input  wire logic          level,
    output acc_pkg::acc_edge_t edges
);
    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = enable ? level : 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign edges.rise = enable & level & ~prev_q;
    assign edges.fall = enable & ~level & prev_q;
endmodule // acc_edge

// ---- acc_irq.sv ----
// Purpose: sticky interrupt status with mask
// Assumes: clear is write-one-to-clear
// Notes:   a set in the clearing cycle wins
module acc_irq #(
    parameter int N = 2
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // events and software access
    input  wire logic [N-1:0] set,
    input  wire logic [N-1:0] clr,
    input  wire logic         mask_we,
    input  wire logic [N-1:0] mask_wdata,
    // state out
    output logic      [N-1:0] status,
    output logic      [N-1:0] mask,
    output logic              irq
);
    logic [N-1:0] sts_q;
    logic [N-1:0] sts_d;
    logic [N-1:0] msk_q;
    logic [N-1:0] msk_d;
    logic         irq_q;
    logic         irq_d;

    always_comb begin
        sts_d = set | (sts_q & ~clr);
        msk_d = mask_we ? mask_wdata : msk_q;
        irq_d = |(sts_d & msk_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= '0;
            msk_q <= '0;
            irq_q <= 1'b0;
        end else begin
            sts_q <= sts_d;
            msk_q <= msk_d;
            irq_q <= irq_d;
        end
    end

    assign status = sts_q;
    assign mask   = msk_q;
    assign irq    = irq_q;
endmodule // acc_irq

// ---- acc_params.svh ----
// Purpose: constants of the comparator control block
// Assumes: 32-bit apb data, registers one aligned word each
// Notes:   low 16 bits carry the comparator register
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
// =====================================================
// register offsets
`define ACC_OFF_CTRL    12'h000
`define ACC_OFF_STAT    12'h004
`define ACC_OFF_MASK    12'h008
`define ACC_OFF_LIVE    12'h00c
// =====================================================
// comparator register fields
`define ACC_CTRL_RESET  16'h0000
`define ACC_CTRL_WMASK  16'h07fc
`define ACC_BIT_ON      10
`define ACC_BIT_POL     5
`define ACC_BIT_HYST    2
`define ACC_BIT_RISE    1
`define ACC_BIT_FALL    0
`define ACC_NSEL_LO     8
`define ACC_ROUTE_LO    6
`define ACC_RES_LO      3
// =====================================================
// routing codes
`define ACC_ROUTE_CONV  2'h0
`define ACC_ROUTE_PIN   2'h2
`define ACC_ROUTE_IRQ   2'h3
// =====================================================
// interrupt status bits
`define ACC_IRQ_RISE    0
`define ACC_IRQ_FALL    1
`define ACC_IRQ_RESET   2'h0
`endif

// ---- acc_pkg.sv ----
// Purpose: types of the comparator control block
// Assumes: nothing
// Notes:   field order matches the register layout
package acc_pkg;
    typedef struct packed {
        logic [4:0] rsvd;
        logic       comparator_on;
        logic [1:0] negative_input_select;
        logic [1:0] output_routing;
        logic       output_polarity;
        logic [1:0] response_time_select;
        logic       hysteresis_on;
        logic       rising_edge_flag;
        logic       falling_edge_flag;
    } acc_ctrl_t;

    typedef struct packed {
        logic       comparator_on;
        logic [1:0] negative_input_select;
        logic [1:0] response_time_select;
        logic       hysteresis_on;
    } acc_analog_t;

    typedef struct packed {
        logic       rise;
        logic       fall;
    } acc_edge_t;
endpackage

// ---- acc_sva.sv ----
// Purpose: port assertions of the comparator control block
// Assumes: one wait state; routing and polarity shadowed from apb writes
// Notes:   bound to acc_top from the tb file
module acc_sva #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // apb
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [ADDR_W-1:0]    paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [3:0]           pstrb,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // comparator and targets
    input wire logic                 cmp_result,
    input wire acc_pkg::acc_analog_t analog_cfg,
    input wire logic                 conversion_start,
    input wire logic                 comparator_output_pin,
    input wire logic                 pla_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // shadow of the low control byte
    logic       wr_ctrl;
    logic [1:0] route_q;
    logic       pol_q;
    assign wr_ctrl = psel && penable && pready && pwrite && paddr == '0 && pstrb[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_q <= 2'h0;
            pol_q   <= 1'b0;
        end else if (wr_ctrl) begin
            route_q <= pwdata[7:6];
            pol_q   <= pwdata[5];
        end
    end
    // ==========================================
    // properties
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_rsvd_zero: assert property (
        pready && !pwrite && paddr == '0 |-> prdata[31:11] == 21'h0)
        else $error("reserved control bits read nonzero");
    a_unmapped_err: assert property (
        pready && paddr >= 16 |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_cfg_write: assert property (
        wr_ctrl && pstrb[1] |=> analog_cfg == {$past(pwdata[10:8]), $past(pwdata[4:2])})
        else $error("analog config does not follow write");
    a_pla_off: assert property (
        (!analog_cfg.comparator_on)[*3] |-> !pla_input)
        else $error("output high while disabled");
    a_pla_follow: assert property (
        (analog_cfg.comparator_on && $stable({cmp_result, pol_q}))[*4]
        |-> pla_input == (cmp_result ^ pol_q))
        else $error("logic array input wrong for polarity");
    a_pin_gate: assert property (
        (route_q != 2'h2)[*3] |-> !comparator_output_pin)
        else $error("pin driven while not routed");
    a_pin_follow: assert property (
        (route_q == 2'h2 && $stable(pla_input))[*3] |-> comparator_output_pin == pla_input)
        else $error("pin does not follow output");
    a_conv_gate: assert property (
        (route_q != 2'h0)[*3] |-> !conversion_start)
        else $error("conversion start while not routed");
    a_conv_pulse: assert property (
        conversion_start |=> !conversion_start)
        else $error("conversion start longer than one cycle");
endmodule // acc_sva

// ---- acc_top.sv ----
// Purpose: apb register bank and output routing of the comparator
// Assumes: comparator result synchronous to pclk
// Notes:   one wait state on every apb access
//
// The register offsets and the APB register port were decided locally.
`include "acc_params.svh"

module acc_top #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // analog comparator core
    input  wire logic               cmp_result,
    output acc_pkg::acc_analog_t    analog_cfg,
    // routing targets
    output logic                    conversion_start,
    output logic                    comparator_output_pin,
    output logic                    pla_input,
    output logic                    comparator_irq
);
    // =====================================================
    // parameter check
    generate
        if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
            $error("acc_top: ADDR_W must lie in 4..32");
        end
    endgenerate

    // =====================================================
    // address decode
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_STAT = 2'h1;
    localparam logic [1:0] SEL_MASK = 2'h2;
    localparam logic [1:0] SEL_LIVE = 2'h3;

    function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
        logic [2:0] r;
        r = 3'h0;
        if (a == ADDR_W'(`ACC_OFF_CTRL)) begin
            r = {1'b1, SEL_CTRL};
        end else if (a == ADDR_W'(`ACC_OFF_STAT)) begin
            r = {1'b1, SEL_STAT};
        end else if (a == ADDR_W'(`ACC_OFF_MASK)) begin
            r = {1'b1, SEL_MASK};
        end else if (a == ADDR_W'(`ACC_OFF_LIVE)) begin
            r = {1'b1, SEL_LIVE};
        end
        return r;
    endfunction

    // =====================================================
    // apb handshake
    logic        ready_q;
    logic        ready_d;
    logic        err_q;
    logic        err_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        slverr_q;
    logic        slverr_d;
    logic [2:0]  dec;
    logic        hit;
    logic [1:0]  sel;
    logic        done;
    logic        wr;
    logic [15:0] wbytes;
    logic [15:0] wval;

    assign dec  = decode(paddr);
    assign hit  = dec[2];
    assign sel  = dec[1:0];
    // a write lands at the edge that samples pready high
    assign done = psel & penable & ready_q;
    assign wr   = done & pwrite & hit & ~err_q;
    assign wbytes = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wval   = pwdata[15:0] & wbytes;

    // =====================================================
    // comparator register state
    acc_pkg::acc_ctrl_t ctrl_q;
    acc_pkg::acc_ctrl_t ctrl_d;
    logic               out_q;
    logic               out_d;
    acc_pkg::acc_edge_t edges;
    logic [1:0]         irq_set;
    logic [1:0]         irq_clr;
    logic [1:0]         irq_sts;
    logic [1:0]         irq_msk;
    logic               irq_mask_we;
    logic               irq_line;

    // =====================================================
    // polarity and monitored output
    always_comb begin
        // polarity applied digitally, analog core compares positive > negative
        out_d = ctrl_q.comparator_on & (cmp_result ^ ctrl_q.output_polarity);
    end

    acc_edge u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (ctrl_q.comparator_on),
        .level   (out_q),
        .edges   (edges)
    );

    // =====================================================
    // control register next value
    logic [15:0] ctrl_bits;
    logic [15:0] ctrl_new;
    logic        ctrl_wr;

    assign ctrl_wr = wr & (sel == SEL_CTRL);

    always_comb begin
        ctrl_bits = 16'(ctrl_q);
        ctrl_new  = ctrl_bits;
        if (ctrl_wr) begin
            // stored fields under byte lanes
            ctrl_new = (ctrl_bits & ~(wbytes & `ACC_CTRL_WMASK))
                     | (wval & `ACC_CTRL_WMASK);
            // flags: one clears, zero leaves alone
            if (wval[`ACC_BIT_RISE]) begin
                ctrl_new[`ACC_BIT_RISE] = 1'b0;
            end
            if (wval[`ACC_BIT_FALL]) begin
                ctrl_new[`ACC_BIT_FALL] = 1'b0;
            end
        end
        // reserved bits never hold a one
        ctrl_new[15:11] = 5'h00;
        // hardware set wins over a clear in the same cycle
        if (edges.rise) begin
            ctrl_new[`ACC_BIT_RISE] = 1'b1;
        end
        if (edges.fall) begin
            ctrl_new[`ACC_BIT_FALL] = 1'b1;
        end
        ctrl_d = acc_pkg::acc_ctrl_t'(ctrl_new);
    end

    // =====================================================
    // interrupt status
    logic route_irq;

    assign route_irq   = ctrl_q.output_routing == `ACC_ROUTE_IRQ;
    assign irq_mask_we = wr & (sel == SEL_MASK);

    always_comb begin
        irq_set = 2'h0;
        irq_clr = 2'h0;
        // only the interrupt routing raises events
        irq_set[`ACC_IRQ_RISE] = route_irq & edges.rise;
        irq_set[`ACC_IRQ_FALL] = route_irq & edges.fall;
        if (wr && sel == SEL_STAT) begin
            irq_clr = wval[1:0];
        end
    end

    acc_irq #(
        .N (2)
    ) u_irq (
        .pclk       (pclk),
        .presetn    (presetn),
        .set        (irq_set),
        .clr        (irq_clr),
        .mask_we    (irq_mask_we),
        .mask_wdata (wval[1:0]),
        .status     (irq_sts),
        .mask       (irq_msk),
        .irq        (irq_line)
    );

    // =====================================================
    // output routing
    logic conv_q;
    logic conv_d;
    logic pin_q;
    logic pin_d;
    logic pla_q;
    logic pla_d;
    acc_pkg::acc_analog_t ana_q;
    acc_pkg::acc_analog_t ana_d;

    always_comb begin
        // one-cycle start pulse per rising edge
        conv_d = (ctrl_q.output_routing == `ACC_ROUTE_CONV) & edges.rise;
        // reserved routing code drives no pin, start pulse or interrupt
        pin_d  = (ctrl_q.output_routing == `ACC_ROUTE_PIN) & out_q;
        // logic array sees the output whatever the routing
        pla_d  = out_q;
        ana_d.comparator_on         = ctrl_d.comparator_on;
        // reserved select codes are passed on unchanged
        ana_d.negative_input_select = ctrl_d.negative_input_select;
        ana_d.response_time_select  = ctrl_d.response_time_select;
        ana_d.hysteresis_on         = ctrl_d.hysteresis_on;
    end

    // =====================================================
    // apb answer
    always_comb begin
        ready_d = 1'b0;
        err_d   = err_q;
        rdata_d = rdata_q;
        if (psel && penable && !ready_q) begin
            // one wait state gives registered answers
            ready_d = 1'b1;
            err_d   = ~hit;
            rdata_d = 32'h0000_0000;
            if (!pwrite && hit) begin
                if (sel == SEL_CTRL) begin
                    rdata_d = {16'h0000, ctrl_bits};
                end else if (sel == SEL_STAT) begin
                    rdata_d = {30'h0, irq_sts};
                end else if (sel == SEL_MASK) begin
                    rdata_d = {30'h0, irq_msk};
                end else begin
                    rdata_d = {31'h0, out_q};
                end
            end
            // the live view takes no writes
            if (pwrite && hit && sel == SEL_LIVE) begin
                err_d = 1'b1;
            end
        end else if (!psel) begin
            err_d = 1'b0;
        end
        // error flag registered on its own so the port comes from a flop
        slverr_d = ready_d & err_d;
    end

    // =====================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= acc_pkg::acc_ctrl_t'(`ACC_CTRL_RESET);
            out_q   <= 1'b0;
            conv_q  <= 1'b0;
            pin_q   <= 1'b0;
            pla_q   <= 1'b0;
            ana_q   <= '0;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            out_q   <= out_d;
            conv_q  <= conv_d;
            pin_q   <= pin_d;
            pla_q   <= pla_d;
            ana_q   <= ana_d;
            ready_q <= ready_d;
            err_q   <= err_d;
            rdata_q <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    // =====================================================
    // outputs
    assign prdata                = rdata_q;
    assign pready                = ready_q;
    assign pslverr               = slverr_q;
    assign analog_cfg            = ana_q;
    assign conversion_start      = conv_q;
    assign comparator_output_pin = pin_q;
    assign pla_input             = pla_q;
    assign comparator_irq        = irq_line;
endmodule // acc_top

// ---- tb.sv ----
// Purpose: self-checking bench of the comparator control block
// Assumes: apb master waits for pready
// Notes:   settle time of 12 cycles covers the slowest response code
`include "acc_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [15:0] c;
        logic [11:0] p;
        logic [11:0] m3;
        logic [11:0] mc;
        logic        o;
    } acc_row_t;
    // ==========================================
    // signals
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic                 cmp_result, conversion_start, comparator_output_pin;
    logic                 pla_input, comparator_irq;
    logic [11:0]          paddr, pos_mv, ch3_mv, conv_mv;
    logic [31:0]          pwdata, prdata, r;
    logic [3:0]           pstrb;
    acc_pkg::acc_analog_t analog_cfg;
    int                   miscompares, checks_done, conv_n, n0;
    acc_row_t rows [6] = '{
        '{16'h0500, 12'd100, 12'd50, 12'd900, 1'b1},
        '{16'h0620, 12'd100, 12'd50, 12'd900, 1'b1},
        '{16'h0598, 12'd10,  12'd50, 12'd900, 1'b0},
        '{16'h05cc, 12'd60,  12'd50, 12'd900, 1'b1},
        '{16'h0690, 12'd500, 12'd50, 12'd100, 1'b1},
        '{16'h0160, 12'd500, 12'd50, 12'd100, 1'b0}};
    acc_top #(.ADDR_W(12)) acc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .cmp_result, .analog_cfg,
        .conversion_start, .comparator_output_pin, .pla_input, .comparator_irq);
    acc_cmp_model acc_cmp_model_i (.pclk, .presetn, .cfg(analog_cfg), .pos_mv, .ch3_mv,
        .conv_mv, .cmp_result);
    // ==========================================
    // tasks
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic conclude();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================
    // clock, monitor, watchdog
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (conversion_start === 1'b1)
            conv_n++;
    end
    initial begin
        // run needs well under a thousand cycles
        repeat (20000) @(posedge pclk);
        miscompares++;
        conclude();
    end
    // ==========================================
    // main sequence
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        {pos_mv, ch3_mv, conv_mv} = 36'h0;
        miscompares = 0;
        checks_done = 0;
        conv_n = 0;
        tick(16);
        presetn <= 1'b1;
        tick(1);
        foreach (rows[i]) begin
            pos_mv  <= rows[i].p;
            ch3_mv  <= rows[i].m3;
            conv_mv <= rows[i].mc;
            wr(12'h000, {16'h0, rows[i].c});
            tick(12);
            check(pla_input, rows[i].o);
            check(comparator_output_pin, rows[i].o & (rows[i].c[7:6] == 2'h2));
            check(analog_cfg, {rows[i].c[10:8], rows[i].c[4:2]});
            rd(12'h000);
            check(r & `ACC_CTRL_WMASK, rows[i].c & `ACC_CTRL_WMASK);
            rd(12'h00c);
            check(r, rows[i].o);
        end
        pos_mv <= 12'd10;
        wr(12'h000, 32'h500);
        tick(12);
        wr(12'h000, 32'h503);
        n0 = conv_n;
        pos_mv <= 12'd90;
        tick(12);
        check(conv_n - n0, 32'h1);
        rd(12'h000);
        check(r & 32'h3, 32'h2);
        pos_mv <= 12'd10;
        tick(12);
        rd(12'h000);
        check(r & 32'h3, 32'h3);
        wr(12'h000, 32'h500);
        rd(12'h000);
        check(r & 32'h3, 32'h3);
        wr(12'h000, 32'h502);
        tick(20);
        rd(12'h000);
        check(r & 32'h3, 32'h1);
        wr(12'h000, 32'h501);
        rd(12'h000);
        check(r & 32'h3, 32'h0);
        wr(12'h008, 32'h3);
        wr(12'h000, 32'h5c3);
        tick(12);
        wr(12'h004, 32'h3);
        pos_mv <= 12'd90;
        tick(12);
        rd(12'h004);
        check(r, 32'h1);
        check(comparator_irq, 1'b1);
        wr(12'h008, 32'h0);
        tick(3);
        check(comparator_irq, 1'b0);
        wr(12'h004, 32'h1);
        rd(12'h004);
        check(r, 32'h0);
        rd(12'h010);
        check(r, 32'h0);
        check(e, 1'b1);
        wr(12'h00c, 32'h0);
        check(e, 1'b1);
        rd(12'h00c);
        check(r, 32'h1);
        apb(1'b1, 12'h000, 32'h4ff, 4'h2);
        rd(12'h000);
        check(r & `ACC_CTRL_WMASK, 32'h4c0);
        presetn <= 1'b0;
        tick(2);
        check({pready, pslverr, conversion_start, pla_input, analog_cfg}, 32'h0);
        presetn <= 1'b1;
        tick(1);
        rd(12'h000);
        check(r, 32'h0);
        conclude();
    end
endmodule // tb
bind acc_top acc_sva #(.ADDR_W(ADDR_W)) acc_sva_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cmp_result,
    .analog_cfg, .conversion_start, .comparator_output_pin, .pla_input);
